/* include/idle_pkg.sv */
// Purpose: Shared constants and types of the idle domain wake-up control.
// Assumes: AHB-Lite register words, one register per word index.
// Notes: Byte address of each register is four times its index.
package idle_pkg;
    localparam int unsigned ADDR_LSB = 2;
    localparam int unsigned IDX_W    = 16;
    typedef logic [IDX_W-1:0] reg_idx_t;
    typedef logic [15:0]      reg_word_t;

    // Register indices.
    localparam reg_idx_t IDX_IDLE_CONFIGURATION      = 16'h0001;
    localparam reg_idx_t IDX_IDLE_STATUS             = 16'h0002;
    localparam reg_idx_t IDX_PLL_CONTROL_STATUS      = 16'h0003;
    localparam reg_idx_t IDX_WAKE_SOURCE_ENABLE      = 16'h0004;
    localparam reg_idx_t IDX_EXTERNAL_BUS_SELECT     = 16'h0005;
    localparam reg_idx_t IDX_INTERRUPT_ENABLE        = 16'h0006;
    localparam reg_idx_t IDX_PERIPHERAL_IDLE_CONTROL = 16'h9400;
    localparam reg_idx_t IDX_PERIPHERAL_IDLE_STATUS  = 16'h9401;
    localparam reg_idx_t IDX_MASTER_IDLE_CONTROL     = 16'h9402;
    localparam reg_idx_t IDX_MASTER_IDLE_STATUS      = 16'h9403;

    // Idle configuration fields.
    localparam int unsigned CFG_W       = 10;
    localparam int unsigned CORE_BIT    = 0;
    localparam int unsigned MASTER_BIT  = 1;
    localparam int unsigned ICACHE_BIT  = 2;
    localparam int unsigned PERIPH_BIT  = 3;
    localparam int unsigned CLKGEN_BIT  = 4;
    localparam int unsigned EXTMEM_BIT  = 5;
    localparam int unsigned XPORT_BIT   = 6;
    localparam int unsigned MPORT_BIT   = 7;
    localparam int unsigned IPORT_BIT   = 8;
    localparam int unsigned CLKEXT_BIT  = 9;
    typedef logic [CFG_W-1:0] idle_cfg_t;
    localparam idle_cfg_t CFG_RESET      = 10'h000;
    // Bits that must accompany a clock generator idle request.
    localparam idle_cfg_t CLK_COMPANIONS = 10'h3E7;
    // Status bits cleared by an interrupt wake-up.
    localparam idle_cfg_t WAKE_CLEAR     = 10'h171;

    // PLL control/status fields.
    localparam int unsigned PLL_PWRDN_BIT = 0;
    localparam int unsigned PLL_RST_BIT   = 1;
    localparam int unsigned PLL_EN_BIT    = 2;
    localparam int unsigned OSC_PWRDN_BIT = 3;
    localparam int unsigned PLL_LOCK_BIT  = 4;
    localparam logic [3:0]  PLL_RESET     = 4'h2;

    // Wake sources: four external lines then the non-maskable one.
    localparam int unsigned WAKE_W     = 5;
    localparam int unsigned NMI_BIT    = 4;
    localparam logic [4:0]  WAKE_RESET = 5'h1F;

    // Multiplexed modules: serial port 2, UART, external memory.
    localparam int unsigned MUX_W     = 3;
    localparam logic [2:0]  MUX_RESET = 3'h7;

    // Serial port and DMA positions in the peripheral and master words.
    localparam int unsigned SPORT_BIT = 0;
    localparam int unsigned DMA_BIT   = 0;

    // Oscillator settling in reference clock cycles.
    localparam int unsigned SETTLE_CYCLES = 41032;
    localparam int unsigned SETTLE_W      = 16;
endpackage : idle_pkg

/* include/idle_link_if.sv */
// Purpose: Carries settle-timer and auto-wake signals inside the block.
// Assumes: One clock, hclk.
// Notes: No clocking block.
`timescale 1ns/1ps
`default_nettype none
interface idle_link_if;
    logic settle_start;  // Restart the oscillator settle count.
    logic settle_busy;   // Count running.
    logic sport_idle;    // Serial port armed idle.
    logic dma_idle;      // DMA armed idle.
    logic ext_clk;       // Serial port on external clock.
    logic xfer_start;    // Incoming transfer begins.
    logic xfer_done;     // Transfer moved to memory.
    logic awake;         // Auto-woken transfer in progress.
    modport ctrl (output settle_start, sport_idle, dma_idle, ext_clk, xfer_start, xfer_done,
                  input settle_busy, awake);
    modport settle (input settle_start, output settle_busy);
    modport autowake (input sport_idle, dma_idle, ext_clk, xfer_start, xfer_done, output awake);
endinterface : idle_link_if
`default_nettype wire

/* verilog/osc_settle_timer.sv */
// Purpose: Oscillator settling count-down.
// Assumes: Counts down on each rising hclk edge until zero, then holds.
// Notes: Busy from reset release and after each restart.
`timescale 1ns/1ps
`default_nettype none
module osc_settle_timer #(
    parameter int unsigned CYCLES = idle_pkg::SETTLE_CYCLES
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    idle_link_if.settle lnk
);
    import idle_pkg::*;
    logic [SETTLE_W-1:0] count_reg;

    // A restart reloads the full count; the core stays held until it runs out.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= SETTLE_W'(CYCLES - 1);
        end else if (lnk.settle_start) begin
            count_reg <= SETTLE_W'(CYCLES - 1);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign lnk.settle_busy = (count_reg != '0);
endmodule : osc_settle_timer
`default_nettype wire

/* verilog/sport_autowake.sv */
// Purpose: Auto wake and re-idle of the serial port and DMA.
// Assumes: Transfer start and done are one-cycle pulses.
// Notes: Only wakes while both are idled and the port runs on an external clock.
`timescale 1ns/1ps
`default_nettype none
module sport_autowake (
    input  wire logic    clk,
    input  wire logic    rst_n,
    idle_link_if.autowake lnk
);
    typedef enum logic {AW_SLEEP, AW_MOVE} aw_state_t;
    aw_state_t state_reg;

    // Wake on a new transfer and fall back to idle once it completes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= AW_SLEEP;
        end else begin
            unique case (state_reg)
                AW_SLEEP: begin
                    if (lnk.sport_idle && lnk.dma_idle && lnk.ext_clk && lnk.xfer_start) begin
                        state_reg <= AW_MOVE;
                    end
                end
                AW_MOVE: begin
                    if (lnk.xfer_done || !(lnk.sport_idle && lnk.dma_idle)) begin
                        state_reg <= AW_SLEEP;
                    end
                end
            endcase
        end
    end

    assign lnk.awake = (state_reg == AW_MOVE);
endmodule : sport_autowake
`default_nettype wire

/* verilog/idle_wakeup_ctrl.sv */
// Purpose: Idle domain gating and wake-up control with an AHB-Lite register file.
// Assumes: Core signals idle instruction execution by a one-cycle pulse.
// Notes: Zero-wait-state slave; settle count runs on hclk as reference clock.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module idle_wakeup_ctrl #(
    parameter int unsigned SETTLE_CYCLES = idle_pkg::SETTLE_CYCLES
) (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,

    input  wire logic                        idle_exec,
    input  wire logic                        nmi_in,
    input  wire logic [3:0]                  ext_int,
    input  wire logic                        onchip_irq,
    input  wire logic                        pll_lock,
    input  wire logic                        sport_ext_clk,
    input  wire logic                        sport_xfer_start,
    input  wire logic                        sport_xfer_done,
    input  wire logic [idle_pkg::MUX_W-1:0]  mux_access,

    output logic      [idle_pkg::CFG_W-1:0]  domain_idle,
    output logic      [15:0]                 periph_idle,
    output logic      [15:0]                 master_idle,
    output logic      [idle_pkg::MUX_W-1:0]  mux_clk_en,
    output logic                             core_hold,
    output logic                             bus_error_irq,
    output logic                             pll_power_down,
    output logic                             pll_hold_reset,
    output logic                             pll_core_select,
    output logic                             oscillator_enable
);
    import idle_pkg::*;

    idle_link_if lnk ();

    logic                 wr_pend_reg;
    reg_idx_t             wr_idx_reg;

    idle_cfg_t            cfg_reg;
    idle_cfg_t            stat_reg;
    reg_word_t            pctl_reg;
    reg_word_t            pstat_reg;
    reg_word_t            mctl_reg;
    reg_word_t            mstat_reg;

    logic [3:0]           pll_reg;
    logic [WAKE_W-1:0]    wake_source_enable_reg;
    logic [MUX_W-1:0]     xbs_reg;
    logic [3:0]           ier_reg;

    logic                 settling_reg;

    logic [31:0]          rdata_reg;
    logic                 berr_reg;
    logic                 core_hold_reg;
    logic [15:0]          pidle_reg;
    logic [15:0]          midle_reg;
    logic [4:0]           pllo_reg;

    // Word index of a byte address on the bus.
    function automatic reg_idx_t addr_index(input logic [31:0] a);
        addr_index = a[ADDR_LSB +: IDX_W];
    endfunction : addr_index

    // Read view of every mapped register; unmapped words read as zero.
    function automatic reg_word_t read_word(input reg_idx_t idx);
        read_word = '0;
        unique case (idx)
            IDX_IDLE_CONFIGURATION:      read_word = {6'h00, cfg_reg};
            IDX_IDLE_STATUS:             read_word = {6'h00, stat_reg};
            IDX_PLL_CONTROL_STATUS:      read_word = {11'h000, pll_lock, pll_reg};
            IDX_WAKE_SOURCE_ENABLE:      read_word = {11'h000, wake_source_enable_reg};
            IDX_EXTERNAL_BUS_SELECT:     read_word = {13'h0000, xbs_reg};
            IDX_INTERRUPT_ENABLE:        read_word = {12'h000, ier_reg};
            IDX_PERIPHERAL_IDLE_CONTROL: read_word = pctl_reg;
            IDX_PERIPHERAL_IDLE_STATUS:  read_word = pstat_reg;
            IDX_MASTER_IDLE_CONTROL:     read_word = mctl_reg;
            IDX_MASTER_IDLE_STATUS:      read_word = mstat_reg;
            default:                     read_word = '0;
        endcase
    endfunction : read_word

    // Bus address phase and write strobe in the following data phase.
    logic addr_ok;
    logic wr_now;

    assign addr_ok = hsel && hready && htrans[1];
    assign wr_now  = wr_pend_reg;

    // Address phase: latch writes, and fetch read data so it stands in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= '0;
            rdata_reg   <= '0;
        end else if (hready) begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_idx_reg  <= addr_index(haddr);
            if (addr_ok && !hwrite) begin
                rdata_reg <= {16'h0000, read_word(addr_index(haddr))};
            end
        end
    end

    // The slave never stretches a transfer and always answers OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Idle instruction with the clock generator bit set is legal only with the full companion set armed.
    logic clk_bad;

    assign clk_bad = cfg_reg[CLKGEN_BIT] && ((cfg_reg & CLK_COMPANIONS) != CLK_COMPANIONS);

    // Wake detection. Deep idle only listens to the selected external lines and the selected non-maskable source.
    logic ext_wake;
    logic deep_wake;
    logic any_wake;

    assign ext_wake  = |(ext_int & ier_reg & wake_source_enable_reg[3:0]);
    assign deep_wake = ext_wake || (nmi_in && wake_source_enable_reg[NMI_BIT]);
    assign any_wake  = deep_wake || |(ext_int & ier_reg) || nmi_in || onchip_irq;

    // Configuration: armed by software, changed only by the bus, cleared by reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg <= CFG_RESET;
        end else if (wr_now && wr_idx_reg == IDX_IDLE_CONFIGURATION) begin
            cfg_reg <= hwdata[CFG_W-1:0];
        end
    end

    // Domain status. Writes from software never reach it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_reg     <= CFG_RESET;
            settling_reg <= 1'b0;
        end else if (stat_reg[CLKGEN_BIT]) begin
            // Clock generator off: only the selected external lines and the selected non-maskable source get through.
            if (deep_wake) begin
                stat_reg     <= stat_reg & ~WAKE_CLEAR;
                settling_reg <= pll_reg[OSC_PWRDN_BIT];
            end
        end else if (stat_reg[CORE_BIT]) begin
            if (any_wake) begin
                stat_reg <= stat_reg & ~WAKE_CLEAR;
            end
        end else if (idle_exec && !clk_bad) begin
            stat_reg <= cfg_reg;
        end else if (settling_reg && !lnk.settle_busy) begin
            settling_reg <= 1'b0;
        end
    end

    // The settle count restarts at the oscillator wake-up.
    assign lnk.settle_start = stat_reg[CLKGEN_BIT] && deep_wake && pll_reg[OSC_PWRDN_BIT];

    // Program flow is held through the settle count after reset or oscillator wake-up.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_hold_reg <= 1'b1;
        end else begin
            core_hold_reg <= lnk.settle_busy || lnk.settle_start;
        end
    end

    // Bus error interrupt for an illegal clock generator idle or a gated module access.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            berr_reg <= 1'b0;
        end else begin
            berr_reg <= (idle_exec && !stat_reg[CORE_BIT] && clk_bad)
                        || |(mux_access & ~xbs_reg);
        end
    end

    // Peripheral and master control words: software writes arm them only.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pctl_reg <= '0;
            mctl_reg <= '0;
        end else if (wr_now) begin
            if (wr_idx_reg == IDX_PERIPHERAL_IDLE_CONTROL) begin
                pctl_reg <= hwdata[15:0];
            end
            if (wr_idx_reg == IDX_MASTER_IDLE_CONTROL) begin
                mctl_reg <= hwdata[15:0];
            end
        end
    end

    // The idle instruction applies armed peripheral and master settings.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pstat_reg <= '0;
            mstat_reg <= '0;
        end else if (idle_exec && !stat_reg[CORE_BIT] && !clk_bad) begin
            pstat_reg <= cfg_reg[PERIPH_BIT] ? pctl_reg : '0;
            mstat_reg <= cfg_reg[MASTER_BIT] ? mctl_reg : '0;
        end
    end

    // PLL, wake source, bus select and interrupt enable words.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_reg  <= PLL_RESET;
            wake_source_enable_reg <= WAKE_RESET;
            xbs_reg  <= MUX_RESET;
            ier_reg  <= '0;
        end else if (wr_now) begin
            unique case (wr_idx_reg)
                IDX_PLL_CONTROL_STATUS:  pll_reg  <= hwdata[3:0];
                IDX_WAKE_SOURCE_ENABLE:  wake_source_enable_reg <= hwdata[WAKE_W-1:0];
                IDX_EXTERNAL_BUS_SELECT: xbs_reg  <= hwdata[MUX_W-1:0];
                IDX_INTERRUPT_ENABLE:    ier_reg  <= hwdata[3:0];
                default:                 ;
            endcase
        end
    end

    // Serial port and DMA auto-wake works on the armed idle states.
    assign lnk.sport_idle = pstat_reg[SPORT_BIT];
    assign lnk.dma_idle   = mstat_reg[DMA_BIT];
    assign lnk.ext_clk    = sport_ext_clk;
    assign lnk.xfer_start = sport_xfer_start;
    assign lnk.xfer_done  = sport_xfer_done;

    // Effective idle lines; an auto-woken transfer lifts both for its duration.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pidle_reg <= '0;
            midle_reg <= '0;
        end else begin
            pidle_reg <= pstat_reg;
            midle_reg <= mstat_reg;
            if (lnk.awake) begin
                pidle_reg[SPORT_BIT] <= 1'b0;
                midle_reg[DMA_BIT]   <= 1'b0;
            end
        end
    end

    // PLL controls and the clock source switch; the oscillator stops only in deep idle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pllo_reg <= {1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        end else begin
            pllo_reg[0] <= pll_reg[PLL_PWRDN_BIT] && stat_reg[CLKGEN_BIT];
            pllo_reg[1] <= pll_reg[PLL_RST_BIT];
            pllo_reg[2] <= pll_reg[PLL_EN_BIT] && !pll_reg[PLL_RST_BIT];
            pllo_reg[3] <= !(pll_reg[OSC_PWRDN_BIT] && stat_reg[CLKGEN_BIT]) || deep_wake;
            pllo_reg[4] <= 1'b0;
        end
    end

    // Clock enables of the multiplexed modules follow the bus selection.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mux_clk_en <= '0;
        end else begin
            mux_clk_en <= xbs_reg;
        end
    end

    osc_settle_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk   (hclk),
        .rst_n (hresetn),
        .lnk   (lnk)
    );

    sport_autowake u_autowake (
        .clk   (hclk),
        .rst_n (hresetn),
        .lnk   (lnk)
    );

    // Outputs, each taken from its flip-flop.
    assign hrdata            = rdata_reg;

    assign domain_idle       = stat_reg;
    assign periph_idle       = pidle_reg;
    assign master_idle       = midle_reg;
    assign core_hold         = core_hold_reg;
    assign bus_error_irq     = berr_reg;

    assign pll_power_down    = pllo_reg[0];
    assign pll_hold_reset    = pllo_reg[1];
    assign pll_core_select   = pllo_reg[2];
    assign oscillator_enable = pllo_reg[3];
endmodule : idle_wakeup_ctrl
`default_nettype wire

/* dv/idle_wakeup_ctrl_assertions.sv */
// Purpose: Port-level checks of the idle wake-up control.
// Assumes: One clock, hclk; hresetn async active low.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module idle_wakeup_ctrl_assertions
    import idle_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = idle_pkg::SETTLE_CYCLES
) (
    input wire logic                       hclk,
    input wire logic                       hresetn,
    input wire logic                       idle_exec,
    input wire logic                       nmi_in,
    input wire logic [3:0]                 ext_int,
    input wire logic                       onchip_irq,
    input wire logic                       sport_ext_clk,
    input wire logic                       sport_xfer_start,
    input wire logic [idle_pkg::MUX_W-1:0] mux_access,
    input wire logic [idle_pkg::CFG_W-1:0] domain_idle,
    input wire logic [15:0]                periph_idle,
    input wire logic [15:0]                master_idle,
    input wire logic [idle_pkg::MUX_W-1:0] mux_clk_en,
    input wire logic                       core_hold,
    input wire logic                       bus_error_irq,
    input wire logic                       pll_hold_reset,
    input wire logic                       pll_core_select
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        hold_seen;
    logic [31:0] hold_cnt;
    // The hold after reset is skipped, since it begins while reset is asserted.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_seen <= 1'b0;
            hold_cnt  <= '0;
        end else if (!core_hold) begin
            hold_seen <= 1'b1;
            hold_cnt  <= '0;
        end else if (hold_seen) begin
            hold_cnt <= hold_cnt + 32'h1;
        end
    end
    // Auto-wake happens in two steps: armed idle, then lifted lines.
    sequence s_armed;
        periph_idle[SPORT_BIT] && master_idle[DMA_BIT] && sport_ext_clk;
    endsequence
    sequence s_lifted;
        !periph_idle[SPORT_BIT] && !master_idle[DMA_BIT];
    endsequence
    property p_autowake;
        s_armed ##0 sport_xfer_start |-> ##[2:3] s_lifted;
    endproperty
    property p_wake_onchip;
        domain_idle[CORE_BIT] && !domain_idle[CLKGEN_BIT] && onchip_irq |=> ((domain_idle & WAKE_CLEAR) == '0)
            && ((domain_idle & ~WAKE_CLEAR) == ($past(domain_idle) & ~WAKE_CLEAR));
    endproperty
    property p_deep_hold;
        domain_idle[CLKGEN_BIT] && onchip_irq && !nmi_in && ext_int == 4'h0 |=> domain_idle[CORE_BIT];
    endproperty
    property p_arm_only;
        !idle_exec && !nmi_in && ext_int == 4'h0 && !onchip_irq |=> $stable(domain_idle);
    endproperty
    property p_hold_len;
        hold_seen && $fell(core_hold) |-> hold_cnt == SETTLE_CYCLES;
    endproperty
    property p_pll_sel;
        pll_core_select |-> !pll_hold_reset;
    endproperty
    property p_mux_err;
        (mux_access & ~mux_clk_en) != 3'h0 |=> bus_error_irq;
    endproperty
    property p_err_cause;
        bus_error_irq |-> $past(idle_exec) || $past(mux_access) != 3'h0;
    endproperty
    a_autowake: assert property (p_autowake) else $error("auto-wake did not lift");
    a_wake_onchip: assert property (p_wake_onchip) else $error("light wake status wrong");
    a_deep_hold: assert property (p_deep_hold) else $error("on-chip irq woke deep idle");
    a_arm_only: assert property (p_arm_only) else $error("status moved without cause");
    a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
    a_pll_sel: assert property (p_pll_sel) else $error("pll selected in reset");
    a_mux_err: assert property (p_mux_err) else $error("gated access without error");
    a_err_cause: assert property (p_err_cause) else $error("bus error without cause");
endmodule : idle_wakeup_ctrl_assertions
`default_nettype wire

/* dv/idle_wakeup_ctrl_test.sv */
// Purpose: Directed register and wake-up tests.
// Assumes: Single AHB-Lite master; settle count shortened to 16.
// Notes: Stimulus changes by non-blocking assignment after rising edges.
`timescale 1ns/1ps
`default_nettype none
module idle_wakeup_ctrl_test;
    import idle_pkg::*;
    logic                   hclk, hresetn, hwrite, idle_exec, onchip_irq, pll_lock, hreadyout, hresp, nmi_in;
    logic                   sport_ext_clk, sport_xfer_start, sport_xfer_done, core_hold, bus_error_irq;
    logic                   pll_power_down, pll_hold_reset, pll_core_select, oscillator_enable;
    logic [1:0]             htrans;
    logic [3:0]             ext_int;
    logic [2:0]             mux_access, mux_clk_en;
    logic [31:0]            haddr, hwdata, hrdata, rdata;
    logic [CFG_W-1:0]       domain_idle;
    logic [15:0]            periph_idle, master_idle;
    int                     fails, compares, n;
    idle_wakeup_ctrl #(.SETTLE_CYCLES(16)) u_idle_wakeup_ctrl (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .idle_exec,
        .nmi_in, .ext_int, .onchip_irq, .pll_lock, .sport_ext_clk, .sport_xfer_start, .sport_xfer_done,
        .mux_access, .domain_idle, .periph_idle, .master_idle, .mux_clk_en, .core_hold, .bus_error_irq,
        .pll_power_down, .pll_hold_reset, .pll_core_select, .oscillator_enable);
    task automatic conclude();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for hready; a hang ends the run.
    task automatic rdy();
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fails++;
            conclude();
        end
    endtask : rdy
    task automatic xfer(input logic w, input reg_idx_t i, input logic [15:0] d);
        @(posedge hclk);
        haddr  <= {14'h0, i, 2'b00};
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        rdy();
        rdata = hrdata;
        chk(hresp, 0);
    endtask : xfer
    // One-cycle pulse on one of the event inputs.
    task automatic pulse(input int k, input logic [2:0] v);
        @(posedge hclk);
        case (k)
            0: idle_exec <= 1'b1;
            1: {nmi_in, onchip_irq} <= v[1:0];
            2: mux_access <= v;
            3: sport_xfer_start <= 1'b1;
            default: sport_xfer_done <= 1'b1;
        endcase
        @(posedge hclk);
        {idle_exec, onchip_irq, nmi_in, mux_access, sport_xfer_start, sport_xfer_done} <= '0;
        #1;
    endtask : pulse
    task automatic hold(input logic lvl);
        for (n = 0; core_hold !== lvl && n < 100; n++) @(posedge hclk) #1;
        if (core_hold !== lvl) begin
            fails++;
            conclude();
        end
    endtask : hold
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial begin
        {hresetn, hwrite, idle_exec, onchip_irq, nmi_in, sport_ext_clk, sport_xfer_start, sport_xfer_done} = '0;
        {htrans, haddr, hwdata, ext_int, mux_access} = '0;
        {pll_lock, fails, compares} = {1'b1, 64'h0};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        hold(1'b0);
        chk(core_hold, 0);
        xfer(0, IDX_IDLE_STATUS, 0);
        chk(rdata, 0);
        xfer(1, IDX_IDLE_CONFIGURATION, 16'hFFFF);
        xfer(0, IDX_IDLE_CONFIGURATION, 0);
        chk(rdata, 32'h3FF);
        chk(domain_idle, 0);
        xfer(1, IDX_IDLE_STATUS, 16'hFFFF);
        xfer(0, IDX_IDLE_STATUS, 0);
        chk(rdata, 0);
        xfer(0, 16'h0100, 0);
        chk(rdata, 0);
        xfer(1, IDX_IDLE_CONFIGURATION, 16'h0010);
        pulse(0, 0);
        chk(bus_error_irq, 1);
        chk(domain_idle, 0);
        xfer(1, IDX_IDLE_CONFIGURATION, 16'h0001);
        pulse(0, 0);
        chk(domain_idle, 1);
        pulse(1, 1);
        chk(domain_idle, 0);
        // Deep idle with the oscillator off, woken by line a.
        xfer(1, IDX_INTERRUPT_ENABLE, 16'h0001);
        xfer(1, IDX_WAKE_SOURCE_ENABLE, 16'h000F);
        xfer(1, IDX_PLL_CONTROL_STATUS, 16'h000A);
        xfer(1, IDX_IDLE_CONFIGURATION, 16'h03F7);
        pulse(0, 0);
        chk(domain_idle, 32'h3F7);
        xfer(0, IDX_IDLE_STATUS, 0);
        chk(rdata, 32'h3F7);
        pulse(1, 1);
        chk(domain_idle, 32'h3F7);
        pulse(1, 2);
        chk(domain_idle, 32'h3F7);
        @(posedge hclk);
        ext_int <= 4'h1;
        @(posedge hclk);
        ext_int <= 4'h0;
        #1;
        chk(domain_idle, 32'h286);
        hold(1'b1);
        for (n = 0; core_hold === 1'b1 && n < 100; n++) @(posedge hclk) #1;
        chk(n, 16);
        chk(oscillator_enable, 1);
        xfer(1, IDX_IDLE_CONFIGURATION, 0);
        pulse(0, 0);
        chk(domain_idle, 0);
        xfer(1, IDX_PLL_CONTROL_STATUS, 16'h0004);
        xfer(1, IDX_EXTERNAL_BUS_SELECT, 16'h0006);
        pulse(2, 3'h2);
        chk({pll_power_down, pll_hold_reset, pll_core_select}, 1);
        chk(bus_error_irq, 0);
        chk(mux_clk_en, 6);
        pulse(2, 3'h1);
        chk(bus_error_irq, 1);
        // Serial port and DMA idled, then woken by one transfer.
        xfer(1, IDX_PERIPHERAL_IDLE_CONTROL, 16'h0001);
        xfer(1, IDX_MASTER_IDLE_CONTROL, 16'h0001);
        xfer(1, IDX_IDLE_CONFIGURATION, 16'h000A);
        pulse(0, 0);
        @(posedge hclk);
        sport_ext_clk <= 1'b1;
        #1;
        chk({periph_idle[0], master_idle[0]}, 3);
        pulse(3, 0);
        repeat (3) @(posedge hclk);
        chk({periph_idle[0], master_idle[0]}, 0);
        pulse(4, 0);
        repeat (3) @(posedge hclk);
        chk({periph_idle[0], master_idle[0]}, 3);
        conclude();
    end
endmodule : idle_wakeup_ctrl_test
bind idle_wakeup_ctrl idle_wakeup_ctrl_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_idle_wakeup_ctrl_assertions (
    .hclk, .hresetn, .idle_exec, .nmi_in, .ext_int, .onchip_irq, .sport_ext_clk, .sport_xfer_start, .mux_access,
    .domain_idle, .periph_idle, .master_idle, .mux_clk_en, .core_hold, .bus_error_irq, .pll_hold_reset,
    .pll_core_select);
`default_nettype wire
